/* File: design/fpcs_pkg.sv */
package fpcs_pkg;
  // bus geometry
  localparam int ADDR_W = 24;
  localparam int DATA_W = 16;
  localparam int BLK_LSB = 17; // 128 Kword blocks
  localparam int BLK_W = 7;
  localparam int PART_LSB = 21; // eight partitions
  localparam int PART_W = 3;
  localparam int NUM_PART = 8;
  localparam int CNT_W = 9; // count field is data bits 8..0
  localparam int OUTST_W = 10;
  // command codes, low byte of the data bus
  localparam logic [7:0] CMD_WORD_PGM = 8'h41;
  localparam logic [7:0] CMD_BUF_PGM = 8'hE9;
  localparam logic [7:0] CMD_FACTORY = 8'h80;
  localparam logic [7:0] CMD_CONFIRM = 8'hD0;
  localparam logic [7:0] CMD_SUSPEND = 8'hB0;
  localparam logic [7:0] CMD_RD_STATUS = 8'h70;
  localparam logic [7:0] CMD_RD_ARRAY = 8'hFF;
  localparam logic [7:0] CMD_CLR_STATUS = 8'h50;
  // status bit positions
  localparam int SB_READY = 7;
  localparam int SB_SEQ = 5;
  localparam int SB_PGM_ERR = 4;
  localparam int SB_SUPPLY = 3;
  localparam int SB_SUSP = 2;
  localparam int SB_LOCK = 1;
  // program stream entry kinds
  localparam logic [1:0] K_WORD = 2'h0;
  localparam logic [1:0] K_STAGE = 2'h1;
  localparam logic [1:0] K_COMMIT = 2'h2;
  localparam logic [1:0] K_DISCARD = 2'h3;
  localparam int ENTRY_W = 2 + ADDR_W + DATA_W;
  // reset values
  localparam logic [NUM_PART-1:0] SMODE_RST = 8'h00;
  // sequencer states, gray steps along the forward paths out of idle
  typedef enum logic [3:0] {
    S_IDLE = 4'h0,
    S_WORD_DATA = 4'h1,
    S_BUSY = 4'h3,
    S_SUSP = 4'h2,
    S_BUF_COUNT = 4'h4,
    S_BUF_LOAD = 4'h5,
    S_BUF_CONF = 4'h7,
    S_FAC_CONF = 4'h8,
    S_FACTORY = 4'hC
  } fpcs_fsm_t;
endpackage

/* File: design/fpcs_buf2.sv */
`timescale 1ns/10ps
`default_nettype none
module fpcs_buf2 #(
  parameter int W = 8
) (
  input wire logic clk_i, // clock
  input wire logic rstn_i, // async reset, active low
  input wire logic in_valid_i, // entry offered
  input wire logic [W-1:0] in_data_i, // entry
  output logic in_ready_o, // room for an entry
  output logic out_valid_o, // head entry valid
  output logic [W-1:0] out_data_o, // head entry
  input wire logic out_ready_i // sink takes head
);
  typedef struct packed {
    logic [W-1:0] s0;
    logic [W-1:0] s1;
    logic v0;
    logic v1;
  } fpcs_buf_t;

  fpcs_buf_t r_ff, nxt_r;
  logic push;
  logic pop;

  // head is always slot 0, so every output is a plain flop
  always_comb begin
    nxt_r = r_ff;
    push = in_valid_i & ~r_ff.v1;
    pop = r_ff.v0 & out_ready_i;
    if (pop) begin
      if (r_ff.v1) begin
        nxt_r.s0 = r_ff.s1;
        nxt_r.s1 = in_data_i;
        nxt_r.v1 = push;
      end else begin
        nxt_r.s0 = in_data_i;
        nxt_r.v0 = push;
      end
    end else if (push) begin
      if (r_ff.v0) begin
        nxt_r.s1 = in_data_i;
        nxt_r.v1 = 1'b1;
      end else begin
        nxt_r.s0 = in_data_i;
        nxt_r.v0 = 1'b1;
      end
    end
  end

  // state register
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      r_ff <= '0;
    end else begin
      r_ff <= nxt_r;
    end
  end

  assign in_ready_o = ~r_ff.v1;
  assign out_valid_o = r_ff.v0;
  assign out_data_o = r_ff.s0;
endmodule // fpcs_buf2
`default_nettype wire

/* File: design/fpcs_seq.sv */
`timescale 1ns/10ps
`default_nettype none
// Summary of operation
// - status read shows machine ready bit
// - supply fault sets error, blocks programming
// - failed word program sets program error
// - locked target aborts, sets lock abort
// - only clear status command clears errors
// - 70h puts partition in status read
// - suspended bit tells suspended versus completed
// - FFh during suspend gives array reads
// - second write latches count minus one
// - load outside setup block aborts sequence
// - confirm must be D0h in same block
// - accepted confirm switches to status read
module fpcs_seq (
  input wire logic REF_CLK_I, // 40 MHz clock
  input wire logic RSTN_I, // async reset, active low
  input wire logic WR_STB_I, // host write cycle, one per word
  input wire logic [fpcs_pkg::ADDR_W-1:0] ADDR_I, // word address of the cycle
  input wire logic [fpcs_pkg::DATA_W-1:0] DATA_I, // write data
  output logic WR_READY_O, // write taken when high with strobe
  input wire logic RD_STB_I, // host read cycle
  input wire logic [fpcs_pkg::DATA_W-1:0] ARRAY_DATA_I, // array word at ADDR_I
  output logic [fpcs_pkg::DATA_W-1:0] RD_DATA_O, // read answer
  output logic RD_VALID_O, // read answer valid
  input wire logic SUPPLY_OK_I, // program supply in range
  input wire logic BLOCK_LOCKED_I, // block at ADDR_I is locked
  output logic PGM_VALID_O, // program stream entry valid
  output logic [1:0] PGM_KIND_O, // entry kind
  output logic [fpcs_pkg::ADDR_W-1:0] PGM_ADDR_O, // entry address
  output logic [fpcs_pkg::DATA_W-1:0] PGM_DATA_O, // entry data
  input wire logic PGM_READY_I, // engine takes entry
  input wire logic PGM_DONE_I, // word or commit finished
  input wire logic PGM_FAIL_I, // with done: it failed
  output logic SUSPEND_O, // engine must hold its work
  output logic FACTORY_MODE_O // factory program mode active
);
  import fpcs_pkg::*;

  typedef struct packed {
    fpcs_fsm_t st;
    logic [NUM_PART-1:0] smode;
    logic pgm_err;
    logic supply_err;
    logic lock_err;
    logic seq_err;
    logic susp;
    logic fac;
    logic [CNT_W-1:0] len;
    logic [CNT_W-1:0] cnt;
    logic [BLK_W-1:0] blk;
    logic [OUTST_W-1:0] outst;
    logic [DATA_W-1:0] rd_data;
    logic rd_valid;
  } fpcs_state_t;

  fpcs_state_t r_ff, nxt_r;
  logic take;
  logic push;
  logic [1:0] push_kind;
  logic in_ready;
  logic [7:0] cmd;
  logic cmd_state;
  logic blk_same;
  logic inc;
  logic [7:0] status;

  function automatic logic [BLK_W-1:0] blk_of(input logic [ADDR_W-1:0] a);
    return a[BLK_LSB +: BLK_W];
  endfunction

  function automatic logic [PART_W-1:0] part_of(input logic [ADDR_W-1:0] a);
    return a[PART_LSB +: PART_W];
  endfunction

  // status byte as seen by a status read
  always_comb begin
    status = 8'h00;
    // ready drops only while the engine works or factory mode runs
    // ready bit
    status[SB_READY] = (r_ff.st != S_BUSY) && !r_ff.fac;
    status[SB_SEQ] = r_ff.seq_err;
    status[SB_PGM_ERR] = r_ff.pgm_err | r_ff.seq_err;
    status[SB_SUPPLY] = r_ff.supply_err;
    status[SB_SUSP] = r_ff.susp;
    status[SB_LOCK] = r_ff.lock_err;
  end

  // command decode and sequencing
  always_comb begin
    nxt_r = r_ff;
    take = WR_STB_I & in_ready;
    cmd = DATA_I[7:0];
    push = 1'b0;
    push_kind = K_WORD;
    blk_same = blk_of(ADDR_I) == r_ff.blk;
    cmd_state = (r_ff.st == S_IDLE) || (r_ff.st == S_BUSY) || (r_ff.st == S_SUSP);
    // read-mode and clear commands are honoured between sequences
    if (take && cmd_state) begin
      if (cmd == CMD_RD_STATUS) nxt_r.smode[part_of(ADDR_I)] = 1'b1;
      if (cmd == CMD_RD_ARRAY) nxt_r.smode[part_of(ADDR_I)] = 1'b0;
      if (cmd == CMD_CLR_STATUS) begin
        nxt_r.pgm_err = 1'b0;
        nxt_r.supply_err = 1'b0;
        nxt_r.lock_err = 1'b0;
        nxt_r.seq_err = 1'b0;
      end
    end
    if (take) begin
      unique case (r_ff.st)
        S_IDLE: begin
          if (cmd == CMD_WORD_PGM || cmd == CMD_BUF_PGM || cmd == CMD_FACTORY ||
              cmd == CMD_SUSPEND) begin
            nxt_r.smode[part_of(ADDR_I)] = 1'b1;
          end
          nxt_r.blk = blk_of(ADDR_I);
          if (cmd == CMD_WORD_PGM) nxt_r.st = S_WORD_DATA;
          if (cmd == CMD_BUF_PGM) nxt_r.st = S_BUF_COUNT;
          if (cmd == CMD_FACTORY) nxt_r.st = S_FAC_CONF;
        end
        S_WORD_DATA: begin
          nxt_r.st = S_IDLE;
          // a latched supply error refuses every further attempt
          // supply refusal
          if (r_ff.supply_err || !SUPPLY_OK_I) begin
            nxt_r.supply_err = 1'b1;
          end else if (BLOCK_LOCKED_I) begin
            nxt_r.lock_err = 1'b1;
          end else begin
            push = 1'b1;
            nxt_r.st = S_BUSY;
          end
        end
        S_BUF_COUNT: begin
          nxt_r.len = DATA_I[CNT_W-1:0];
          nxt_r.cnt = '0;
          nxt_r.st = blk_same ? S_BUF_LOAD : S_IDLE;
          nxt_r.seq_err = r_ff.seq_err | !blk_same;
        end
        S_BUF_LOAD: begin
          push = 1'b1;
          if (!blk_same) begin
            push_kind = K_DISCARD;
            nxt_r.seq_err = 1'b1;
            nxt_r.st = S_IDLE;
          end else begin
            push_kind = K_STAGE;
            nxt_r.cnt = r_ff.cnt + 9'h001;
            if (r_ff.cnt == r_ff.len) nxt_r.st = S_BUF_CONF;
          end
        end
        S_BUF_CONF: begin
          push = 1'b1;
          push_kind = K_DISCARD;
          nxt_r.st = S_IDLE;
          if (!blk_same || cmd != CMD_CONFIRM) begin
            nxt_r.seq_err = 1'b1;
          end else if (r_ff.supply_err || !SUPPLY_OK_I) begin
            nxt_r.supply_err = 1'b1;
          end else if (BLOCK_LOCKED_I) begin
            nxt_r.lock_err = 1'b1;
          end else begin
            push_kind = K_COMMIT;
            nxt_r.st = S_BUSY;
            nxt_r.smode[part_of(ADDR_I)] = 1'b1;
          end
        end
        S_BUSY: begin
          // a request after completion leaves the suspended bit clear
          // suspend request
          if (cmd == CMD_SUSPEND) begin
            nxt_r.smode[part_of(ADDR_I)] = 1'b1;
            nxt_r.st = S_SUSP;
            nxt_r.susp = 1'b1;
          end
        end
        S_SUSP: begin
          if (cmd == CMD_CONFIRM) begin
            nxt_r.st = S_BUSY;
            nxt_r.susp = 1'b0;
          end
        end
        S_FAC_CONF: begin
          nxt_r.st = S_IDLE;
          if (!blk_same || cmd != CMD_CONFIRM) begin
            nxt_r.seq_err = 1'b1;
          end else if (r_ff.supply_err || !SUPPLY_OK_I) begin
            nxt_r.supply_err = 1'b1;
          end else if (BLOCK_LOCKED_I) begin
            nxt_r.lock_err = 1'b1;
          end else begin
            nxt_r.st = S_FACTORY;
            nxt_r.fac = 1'b1;
          end
        end
        S_FACTORY: begin
          // later factory phases are outside this block; array command leaves
          if (cmd == CMD_RD_ARRAY) begin
            nxt_r.st = S_IDLE;
            nxt_r.fac = 1'b0;
          end
        end
        default: nxt_r.st = S_IDLE;
      endcase
    end
    // engine completions; sets land after the clear, so a set wins
    inc = push && (push_kind == K_WORD || push_kind == K_COMMIT);
    nxt_r.outst = r_ff.outst + OUTST_W'(inc) - OUTST_W'(PGM_DONE_I);
    if (PGM_DONE_I && PGM_FAIL_I) nxt_r.pgm_err = 1'b1;
    // busy ends when nothing is queued or in flight; a suspend landing then is void
    if (r_ff.st == S_BUSY && r_ff.outst == '0 && !PGM_VALID_O && !inc) begin
      nxt_r.st = S_IDLE;
      nxt_r.susp = 1'b0;
    end
    // read answer one cycle after the strobe
    nxt_r.rd_valid = RD_STB_I;
    if (RD_STB_I) begin
      nxt_r.rd_data = r_ff.smode[part_of(ADDR_I)] ? {8'h00, status} : ARRAY_DATA_I;
    end
  end

  // state register
  always_ff @(posedge REF_CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      r_ff <= '0;
      r_ff.st <= S_IDLE;
      r_ff.smode <= SMODE_RST;
    end else begin
      r_ff <= nxt_r;
    end
  end

  // program stream buffer; a stalled engine holds off host writes
  fpcs_buf2 #(
    .W(ENTRY_W)
  ) u_buf (
    .clk_i(REF_CLK_I),
    .rstn_i(RSTN_I),
    .in_valid_i(push),
    .in_data_i({push_kind, ADDR_I, DATA_I}),
    .in_ready_o(in_ready),
    .out_valid_o(PGM_VALID_O),
    .out_data_o({PGM_KIND_O, PGM_ADDR_O, PGM_DATA_O}),
    .out_ready_i(PGM_READY_I)
  );

  assign WR_READY_O = in_ready;
  assign RD_DATA_O = r_ff.rd_data;
  assign RD_VALID_O = r_ff.rd_valid;
  assign SUSPEND_O = r_ff.susp;
  assign FACTORY_MODE_O = r_ff.fac;
endmodule // fpcs_seq
`default_nettype wire

/* File: tb/fpcs_seq_props.sv */
`timescale 1ns/10ps
`default_nettype none
module fpcs_seq_props (
  input wire logic REF_CLK_I, // clock
  input wire logic RSTN_I, // reset, active low
  input wire logic WR_STB_I, // write strobe
  input wire logic [fpcs_pkg::DATA_W-1:0] DATA_I, // write data
  input wire logic WR_READY_O, // write accepted
  input wire logic RD_STB_I, // read strobe
  input wire logic [fpcs_pkg::DATA_W-1:0] RD_DATA_O, // read answer
  input wire logic RD_VALID_O, // read answer valid
  input wire logic SUPPLY_OK_I, // supply fine
  input wire logic BLOCK_LOCKED_I, // block locked
  input wire logic PGM_VALID_O, // entry valid
  input wire logic [1:0] PGM_KIND_O, // entry kind
  input wire logic [fpcs_pkg::ADDR_W-1:0] PGM_ADDR_O, // entry address
  input wire logic [fpcs_pkg::DATA_W-1:0] PGM_DATA_O, // entry data
  input wire logic PGM_READY_I, // engine takes entry
  input wire logic SUSPEND_O, // engine hold
  input wire logic FACTORY_MODE_O // factory mode
);
  import fpcs_pkg::*;
  logic tk;
  logic [7:0] cd;
  logic susp_cmd;
  logic conf_cmd;
  logic fac_ok;
  // a write only counts when the buffer had room
  assign tk = WR_STB_I && WR_READY_O;
  assign cd = DATA_I[7:0];
  assign susp_cmd = tk && cd == CMD_SUSPEND;
  assign conf_cmd = tk && cd == CMD_CONFIRM;
  assign fac_ok = conf_cmd && SUPPLY_OK_I && !BLOCK_LOCKED_I;
  default clocking @(posedge REF_CLK_I); endclocking
  default disable iff (!RSTN_I);
  rd_answer_a: assert property (RD_STB_I |=> RD_VALID_O)
    else $error("read not answered");
  rd_pulse_a: assert property (!RD_STB_I |=> !RD_VALID_O && $stable(RD_DATA_O))
    else $error("read answer without read");
  entry_hold_a: assert property (PGM_VALID_O && !PGM_READY_I |=> PGM_VALID_O &&
    $stable({PGM_KIND_O, PGM_ADDR_O, PGM_DATA_O})) else $error("entry changed before taken");
  full_ready_a: assert property (!WR_READY_O |-> PGM_VALID_O)
    else $error("write refused with empty buffer");
  susp_start_a: assert property ($rose(SUSPEND_O) |-> $past(susp_cmd))
    else $error("suspend without command");
  susp_hold_a: assert property (SUSPEND_O && !(tk && cd == CMD_CONFIRM) |=> SUSPEND_O)
    else $error("suspend dropped without resume");
  susp_end_a: assert property ($fell(SUSPEND_O) |-> $past(conf_cmd))
    else $error("resume without command");
  fac_entry_a: assert property ($rose(FACTORY_MODE_O) |-> $past(fac_ok))
    else $error("bad factory entry");
  fac_hold_a: assert property (FACTORY_MODE_O && !(tk && cd == CMD_RD_ARRAY) |=> FACTORY_MODE_O)
    else $error("factory mode left early");
endmodule // fpcs_seq_props
bind fpcs_seq fpcs_seq_props u_fpcs_seq_props (.REF_CLK_I(REF_CLK_I), .RSTN_I(RSTN_I),
  .WR_STB_I(WR_STB_I), .DATA_I(DATA_I), .WR_READY_O(WR_READY_O), .RD_STB_I(RD_STB_I),
  .RD_DATA_O(RD_DATA_O), .RD_VALID_O(RD_VALID_O), .SUPPLY_OK_I(SUPPLY_OK_I),
  .BLOCK_LOCKED_I(BLOCK_LOCKED_I), .PGM_VALID_O(PGM_VALID_O), .PGM_KIND_O(PGM_KIND_O),
  .PGM_ADDR_O(PGM_ADDR_O), .PGM_DATA_O(PGM_DATA_O), .PGM_READY_I(PGM_READY_I),
  .SUSPEND_O(SUSPEND_O), .FACTORY_MODE_O(FACTORY_MODE_O));
`default_nettype wire

/* File: tb/fpcs_engine_model.sv */
`timescale 1ns/10ps
`default_nettype none
module fpcs_engine_model (
  input wire logic clk_i, // clock
  input wire logic rstn_i, // reset, active low
  input wire logic valid_i, // entry offered
  input wire logic [1:0] kind_i, // entry kind
  input wire logic suspend_i, // hold work
  input wire logic stall_i, // refuse entries this cycle
  input wire logic fail_i, // next result fails
  input wire logic [3:0] lat_i, // work length
  output logic ready_o, // entry taken
  output logic done_o, // result pulse
  output logic fail_o // result failed
);
  import fpcs_pkg::*;
  int cnt;
  // one job at a time; fail toggles outside results so it is never trusted alone
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      cnt <= 0;
      done_o <= 1'b0;
      fail_o <= 1'b0;
    end else if (valid_i && ready_o) begin
      cnt <= (kind_i == K_WORD || kind_i == K_COMMIT) ? int'(lat_i) + 1 : 0;
      done_o <= 1'b0;
      fail_o <= ~fail_o;
    end else if (cnt > 0 && !suspend_i) begin
      cnt <= cnt - 1;
      done_o <= (cnt == 1);
      fail_o <= (cnt == 1) ? fail_i : ~fail_o;
    end else begin
      done_o <= 1'b0;
      fail_o <= ~fail_o;
    end
  end
  // a stall backs up the two-entry buffer so the host side sees refusals
  assign ready_o = (cnt == 0) && !stall_i;
endmodule // fpcs_engine_model
`default_nettype wire

/* File: tb/tb_fpcs_seq.sv */
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin err_count++; $display("ERROR %0t: got %h want %h", $time, a, b); end end
module tb_fpcs_seq;
  import fpcs_pkg::*;
  localparam logic [ADDR_W-1:0] A0 = 24'h000100;
  localparam logic [ADDR_W-1:0] A1 = 24'h020100;
  logic ref_clk = 0, rstn = 0, wr_stb = 0, rd_stb = 0, sup_ok = 1, locked = 0, fail = 0;
  logic hold = 0, stall = 0;
  int full_cnt = 0;
  logic [ADDR_W-1:0] addr = '0, paddr;
  logic [DATA_W-1:0] wdata = '0, arr = '0, rd_data, pdata;
  logic [1:0] kind;
  logic [3:0] lat = 4'h2;
  logic wr_rdy, rd_vld, pvalid, pready, pdone, pfail, susp, fac;
  logic [41:0] expq[$], gotq[$];
  int err_count = 0, check_count = 0;
  always #12.5 ref_clk = ~ref_clk;
  fpcs_seq u_fpcs_seq (.REF_CLK_I(ref_clk), .RSTN_I(rstn), .WR_STB_I(wr_stb), .ADDR_I(addr),
    .DATA_I(wdata), .WR_READY_O(wr_rdy), .RD_STB_I(rd_stb), .ARRAY_DATA_I(arr),
    .RD_DATA_O(rd_data), .RD_VALID_O(rd_vld), .SUPPLY_OK_I(sup_ok), .BLOCK_LOCKED_I(locked),
    .PGM_VALID_O(pvalid), .PGM_KIND_O(kind), .PGM_ADDR_O(paddr), .PGM_DATA_O(pdata),
    .PGM_READY_I(pready), .PGM_DONE_I(pdone), .PGM_FAIL_I(pfail), .SUSPEND_O(susp),
    .FACTORY_MODE_O(fac));
  fpcs_engine_model u_fpcs_engine_model (.clk_i(ref_clk), .rstn_i(rstn), .valid_i(pvalid),
    .kind_i(kind), .suspend_i(susp), .stall_i(stall), .fail_i(fail), .lat_i(lat), .ready_o(pready),
    .done_o(pdone), .fail_o(pfail));
  // every entry the engine takes; commit and discard carry no payload worth comparing
  always @(posedge ref_clk) if (pvalid && pready) gotq.push_back(kind < 2 ? {kind, paddr, pdata} : {kind, 40'h0});
  // random engine stalls while hold is up, mostly refusing so the buffer fills
  always @(posedge ref_clk) #2 stall = hold && ($urandom_range(0, 3) != 0);
  // cycles in which the host side was refused
  always @(posedge ref_clk) if (!wr_rdy) full_cnt++;
  function automatic logic [DATA_W-1:0] c16(input logic [7:0] x);
    return {8'h00, x};
  endfunction
  // one write cycle, then an idle cycle so the strobe is never re-driven in one step
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    for (int n = 0; n < 100 && !wr_rdy; n++) begin
      @(posedge ref_clk);
      #2;
    end
    wr_stb = 1;
    addr = a;
    wdata = d;
    @(posedge ref_clk);
    #2;
    wr_stb = 0;
    @(posedge ref_clk);
    #2;
  endtask
  task automatic rd(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] q);
    rd_stb = 1;
    addr = a;
    arr = 16'($urandom);
    @(posedge ref_clk);
    #2;
    rd_stb = 0;
    `CHK(rd_vld, 1'b1)
    q = rd_data;
    @(posedge ref_clk);
    #2;
  endtask
  // poll status until ready, bounded, then compare the whole byte
  task automatic st(input logic [ADDR_W-1:0] a, input logic [7:0] e);
    logic [DATA_W-1:0] q;
    for (int i = 0; i < 200; i++) begin
      rd(a, q);
      if (q[7] === 1'b1) break;
    end
    `CHK(q, c16(e))
  endtask
  task automatic cmpq();
    logic [41:0] g, x;
    `CHK(gotq.size(), expq.size())
    while (gotq.size() > 0 && expq.size() > 0) begin
      g = gotq.pop_front();
      x = expq.pop_front();
      `CHK(g, x)
    end
    gotq = {};
    expq = {};
  endtask
  task automatic wrap_up();
    $display("checks %0d errors %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  initial begin
    logic [DATA_W-1:0] q, d;
    int cnts[3];
    void'($urandom(87985));
    cnts = '{0, $urandom_range(1, 8), 511};
    repeat (4) @(posedge ref_clk);
    #2;
    rstn = 1;
    `CHK(wr_rdy, 1'b1)
    rd(A0, q);
    `CHK(q, arr)
    // word programs with random data and latency, outcome alternating pass and fail
    for (int i = 0; i < 6; i++) begin
      lat = 4'($urandom_range(1, 15));
      fail = i[0];
      d = 16'($urandom);
      wr(A0, c16(CMD_WORD_PGM));
      wr(A0, d);
      expq.push_back({K_WORD, A0, d});
      rd(A0, q);
      `CHK(q[7], 1'b0)
      st(A0, fail ? 8'h90 : 8'h80);
      wr(A0, c16(CMD_RD_ARRAY));
      wr(A0, c16(CMD_RD_STATUS));
      rd(A0, q);
      `CHK(q[7:0], fail ? 8'h90 : 8'h80)
      wr(A0, c16(CMD_CLR_STATUS));
    end
    fail = 0;
    // supply fault sticks and refuses later attempts; locked block aborts
    for (int i = 0; i < 3; i++) begin
      sup_ok = (i != 0);
      locked = (i == 2);
      wr(A0, c16(CMD_WORD_PGM));
      wr(A0, 16'h1111);
      st(A0, i == 2 ? 8'h82 : 8'h88);
      if (i != 0) wr(A0, c16(CMD_CLR_STATUS));
    end
    locked = 0;
    cmpq();
    // suspend mid program, read array elsewhere, resume
    lat = 4'hF;
    wr(A0, c16(CMD_WORD_PGM));
    wr(A0, 16'h1234);
    expq.push_back({K_WORD, A0, 16'h1234});
    wr(A0, c16(CMD_SUSPEND));
    wr(A0, c16(CMD_RD_STATUS));
    st(A0, 8'h84);
    `CHK(susp, 1'b1)
    wr(A0, c16(CMD_RD_ARRAY));
    rd(A1, q);
    `CHK(q, arr)
    wr(A0, c16(CMD_RD_STATUS));
    wr(A0, c16(CMD_CONFIRM));
    `CHK(susp, 1'b0)
    st(A0, 8'h80);
    wr(A0, c16(CMD_SUSPEND));
    st(A0, 8'h80);
    cmpq();
    // buffered loads of one word, a few words and a full buffer, engine stalling
    lat = 4'h3;
    hold = 1;
    foreach (cnts[j]) begin
      wr(A0, c16(CMD_BUF_PGM));
      wr(A0, 16'(cnts[j]));
      for (int k = 0; k <= cnts[j]; k++) begin
        d = 16'($urandom);
        wr(A0 + 24'(k), d);
        expq.push_back({K_STAGE, A0 + 24'(k), d});
      end
      wr(A0, c16(CMD_CONFIRM));
      expq.push_back({K_COMMIT, 40'h0});
      st(A0, 8'h80);
      cmpq();
    end
    hold = 0;
    `CHK(full_cnt > 0, 1'b1)
    // load outside the block, confirm outside the block, confirm with bad data
    for (int j = 0; j < 3; j++) begin
      wr(A0, c16(CMD_BUF_PGM));
      wr(A0, j == 0 ? 16'h0001 : 16'h0000);
      wr(A0, 16'h5555);
      expq.push_back({K_STAGE, A0, 16'h5555});
      wr(j == 2 ? A0 : A1, j == 2 ? 16'h00D1 : c16(CMD_CONFIRM));
      expq.push_back({K_DISCARD, 40'h0});
      st(A0, 8'hB0);
      wr(A0, c16(CMD_CLR_STATUS));
      cmpq();
    end
    // factory mode entry and exit
    wr(A0, c16(CMD_FACTORY));
    wr(A0, c16(CMD_CONFIRM));
    `CHK(fac, 1'b1)
    rd(A0, q);
    `CHK(q[7], 1'b0)
    wr(A0, c16(CMD_RD_ARRAY));
    `CHK(fac, 1'b0)
    wrap_up();
  end
  // the run needs a few thousand cycles; this bound is far beyond it
  initial begin
    #(25 * 90000);
    err_count++;
    wrap_up();
  end
endmodule // tb_fpcs_seq
`default_nettype wire
